//--- hdl/wsc_bus_ctrl.v
// external bus timing control: wait states, bank gaps, keepers, bus-off
`include "wsc_defs.vh"

// Contract
// RULE1: range bit selects program field mapping
// RULE2: I/O field sets all port waits
// RULE3: upper data field for 8000-FFFFh
// RULE4: lower data field for 0000-7FFFh
// RULE5: upper program field for x8000-xFFFFh
// RULE6: extended range makes upper field unused
// RULE7: lower program field, or whole space extended
// RULE8: multiplier bit doubles every base count
// RULE9: reserved bits read zero, ignore writes
// RULE10: one idle cycle on bank change
// RULE11: idle cycle crossing data into program
// RULE12: compare mask selects compared upper bits
// RULE13: turnaround cycle between program/data reads
// RULE14: host keeper enable, off at reset
// RULE15: data bus keeper enable, off at reset
// RULE16: bus-off after current cycle ends
// RULE17: mode bits locked while bus off
// RULE18: seven waits everywhere after reset
// RULE19: gate wait clocks when all zero
// RULE20: ready input extends the bus cycle
// RULE21: wait count plus separate gap cycle
// RULE22: externals answer within programmed waits
module wsc_bus_ctrl (
   clk,
   rst_b,
   mmr_addr,
   mmr_wr,
   mmr_rd,
   mmr_wdata,
   mmr_rdata_q,
   acc_req,
   acc_space,
   acc_rd,
   acc_addr,
   acc_busy_q,
   acc_done_q,
   ext_ready,
   ext_addr_q,
   ext_strobe_b_q,
   ext_rw_q,
   ext_prog_sel_b_q,
   ext_data_sel_b_q,
   ext_io_sel_b_q,
   ext_bus_off_q,
   host_bus_keeper_enable_q,
   data_bus_keeper_enable_q,
   wait_clk_off_q,
   mode_wr,
   mode_wdata,
   data_rom_enable_q,
   boot_mode_select_q,
   ram_overlay_bit_q
);
   input wire clk;
   input wire rst_b;
   // memory-mapped register port
   input wire [15:0] mmr_addr;
   input wire mmr_wr;
   input wire mmr_rd;
   input wire [15:0] mmr_wdata;
   output reg [15:0] mmr_rdata_q;
   // core access request
   input wire acc_req;
   input wire [1:0] acc_space;
   input wire acc_rd;
   input wire [19:0] acc_addr;
   output reg acc_busy_q;
   output reg acc_done_q;
   // external bus
   input wire ext_ready;
   output reg [19:0] ext_addr_q;
   output reg ext_strobe_b_q;
   output reg ext_rw_q;
   output reg ext_prog_sel_b_q;
   output reg ext_data_sel_b_q;
   output reg ext_io_sel_b_q;
   output reg ext_bus_off_q;
   // keepers and power
   output reg host_bus_keeper_enable_q;
   output reg data_bus_keeper_enable_q;
   output reg wait_clk_off_q;
   // processor mode bits guarded by bus-off
   input wire mode_wr;
   input wire [2:0] mode_wdata;
   output reg data_rom_enable_q;
   output reg boot_mode_select_q;
   output reg ram_overlay_bit_q;

   localparam ST_IDLE = 2'd0;
   localparam ST_GAP = 2'd1;
   localparam ST_STRB = 2'd2;

   reg [15:0] ranges_q;
   reg [15:0] bank_q;
   reg [15:0] mult_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   reg [1:0] cur_space_q;
   reg cur_rd_q;
   reg [19:0] cur_addr_q;
   reg prev_valid_q;
   reg [1:0] prev_space_q;
   reg prev_rd_q;
   reg [19:0] prev_addr_q;
   reg bus_off_d;
   reg [15:0] rdata_d;
   wire [3:0] wait_new;
   wire [3:0] wait_cur;
   wire gap_new;
   wire accept;
   wire finish;

   // ---------------------------------------------------------------
   // helpers: range lookup and gap decision
   // ---------------------------------------------------------------
   // lookup on the incoming request, used when no gap is needed
   wsc_wait_calc u_calc_new (
      .ranges(ranges_q),
      .mult(mult_q[`WSC_MULT_BIT]),
      .space(acc_space),
      .addr(acc_addr),
      .wait_cnt(wait_new)
   );

   // lookup on the latched access, used after a gap cycle
   wsc_wait_calc u_calc_cur (
      .ranges(ranges_q),
      .mult(mult_q[`WSC_MULT_BIT]),
      .space(cur_space_q),
      .addr(cur_addr_q),
      .wait_cnt(wait_cur)
   );

   wsc_gap_detect u_gap (
      .bank_mask(bank_q[`WSC_BNK_HI:`WSC_BNK_LO]),
      .turn_en(bank_q[`WSC_TURN_BIT]),
      .prev_valid(prev_valid_q),
      .prev_space(prev_space_q),
      .prev_rd(prev_rd_q),
      .prev_addr(prev_addr_q),
      .space(acc_space),
      .rd(acc_rd),
      .addr(acc_addr),
      .gap(gap_new)
   );

   // ---------------------------------------------------------------
   // request handshake terms
   // ---------------------------------------------------------------
   // requests are taken only while idle and with the bus on
   assign accept = acc_req && (state_q == ST_IDLE) && !ext_bus_off_q;
   // last strobe cycle needs count spent and ready high
   assign finish = (state_q == ST_STRB) && (cnt_q == 4'h0) && ext_ready; // RULE20 RULE22

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // reset gives seven waits on every range
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ranges_q <= `WSC_RST_RANGES; // RULE18
         bank_q <= `WSC_RST_BANK;
         mult_q <= `WSC_RST_MULT;
      end else if (mmr_wr) begin
         if (mmr_addr == `WSC_OFS_RANGES) begin
            ranges_q <= mmr_wdata;
         end
         if (mmr_addr == `WSC_OFS_BANK) begin
            bank_q <= mmr_wdata & `WSC_MASK_BANK; // RULE9
         end
         if (mmr_addr == `WSC_OFS_MULT) begin
            mult_q <= mmr_wdata & `WSC_MASK_MULT; // RULE9
         end
      end
   end

   // ---------------------------------------------------------------
   // register reads, one cycle after the strobe
   // ---------------------------------------------------------------
   always @* begin
      rdata_d = 16'h0000;
      if (mmr_rd) begin
         case (mmr_addr)
            `WSC_OFS_RANGES: rdata_d = ranges_q;
            `WSC_OFS_BANK: rdata_d = bank_q;
            `WSC_OFS_MULT: rdata_d = mult_q;
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mmr_rdata_q <= 16'h0000;
      end else begin
         mmr_rdata_q <= rdata_d;
      end
   end

   // ---------------------------------------------------------------
   // processor mode bits
   // ---------------------------------------------------------------
   // blocked while the off bit is set, so a detached bus cannot be remapped
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         data_rom_enable_q <= 1'b0;
         boot_mode_select_q <= 1'b0;
         ram_overlay_bit_q <= 1'b0;
      end else if (mode_wr && !bank_q[`WSC_BUSOFF_BIT]) begin // RULE17
         data_rom_enable_q <= mode_wdata[2];
         boot_mode_select_q <= mode_wdata[1];
         ram_overlay_bit_q <= mode_wdata[0];
      end
   end

   // ---------------------------------------------------------------
   // access sequencer
   // ---------------------------------------------------------------
   // gap cycle first, then strobe for one plus the wait count
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         ST_IDLE: begin
            if (accept) begin
               if (gap_new) begin
                  state_d = ST_GAP; // RULE10 RULE11 RULE13
               end else begin
                  state_d = ST_STRB;
                  cnt_d = wait_new; // RULE21
               end
            end
         end
         ST_GAP: begin
            // gap is added on top of the range wait count
            state_d = ST_STRB;
            cnt_d = wait_cur; // RULE21
         end
         ST_STRB: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (ext_ready) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = 4'h0;
         end
      endcase
   end

   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // ---------------------------------------------------------------
   // current and previous access bookkeeping
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_space_q <= `WSC_SP_PROG;
         cur_rd_q <= 1'b1;
         cur_addr_q <= 20'h0_0000;
         prev_valid_q <= 1'b0;
         prev_space_q <= `WSC_SP_PROG;
         prev_rd_q <= 1'b0;
         prev_addr_q <= 20'h0_0000;
      end else begin
         if (accept) begin
            cur_space_q <= acc_space;
            cur_rd_q <= acc_rd;
            cur_addr_q <= acc_addr;
         end
         if (finish) begin
            prev_valid_q <= 1'b1;
            prev_space_q <= cur_space_q;
            prev_rd_q <= cur_rd_q;
            prev_addr_q <= cur_addr_q;
         end
      end
   end

   // ---------------------------------------------------------------
   // bus-off state
   // ---------------------------------------------------------------
   // taken when idle with no request or as a cycle finishes, so a cycle never gets cut
   always @* begin
      bus_off_d = ext_bus_off_q;
      if (!bank_q[`WSC_BUSOFF_BIT]) begin
         bus_off_d = 1'b0;
      end else if ((state_q == ST_IDLE) && !acc_req) begin
         bus_off_d = 1'b1; // RULE16
      end else if (finish) begin
         bus_off_d = 1'b1; // RULE16
      end
   end

   // ---------------------------------------------------------------
   // external bus outputs, all registered
   // ---------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_bus_off_q <= 1'b0;
         ext_addr_q <= 20'h0_0000;
         ext_strobe_b_q <= 1'b1;
         ext_rw_q <= 1'b1;
         ext_prog_sel_b_q <= 1'b1;
         ext_data_sel_b_q <= 1'b1;
         ext_io_sel_b_q <= 1'b1;
         acc_busy_q <= 1'b0;
         acc_done_q <= 1'b0;
      end else begin
         ext_bus_off_q <= bus_off_d;
         acc_done_q <= finish;
         acc_busy_q <= (state_d != ST_IDLE);
         if (state_d == ST_STRB) begin
            ext_addr_q <= (state_q == ST_IDLE) ? acc_addr : cur_addr_q;
            ext_strobe_b_q <= 1'b0;
            ext_rw_q <= (state_q == ST_IDLE) ? acc_rd : cur_rd_q;
            ext_prog_sel_b_q <= ((state_q == ST_IDLE) ? acc_space : cur_space_q) != `WSC_SP_PROG;
            ext_data_sel_b_q <= ((state_q == ST_IDLE) ? acc_space : cur_space_q) != `WSC_SP_DATA;
            ext_io_sel_b_q <= ((state_q == ST_IDLE) ? acc_space : cur_space_q) != `WSC_SP_IO;
         end else begin
            // idle, gap or off: strobes and selects inactive
            ext_strobe_b_q <= 1'b1;
            ext_rw_q <= 1'b1;
            ext_prog_sel_b_q <= 1'b1;
            ext_data_sel_b_q <= 1'b1;
            ext_io_sel_b_q <= 1'b1;
            if (bus_off_d) begin
               ext_addr_q <= 20'h0_0000; // RULE16
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // keepers and wait-generator clock gate
   // ---------------------------------------------------------------
   // the gate only saves power; counts of zero need no counter anyway
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         host_bus_keeper_enable_q <= 1'b0;
         data_bus_keeper_enable_q <= 1'b0;
         wait_clk_off_q <= 1'b0;
      end else begin
         host_bus_keeper_enable_q <= bank_q[`WSC_HKEEP_BIT]; // RULE14
         data_bus_keeper_enable_q <= bank_q[`WSC_DKEEP_BIT]; // RULE15
         wait_clk_off_q <= ~|ranges_q[14:0]; // RULE19
      end
   end
endmodule // wsc_bus_ctrl

//--- hdl/wsc_defs.vh
// constants for the external bus wait-state and bank-switch control block
`ifndef WSC_DEFS_VH
`define WSC_DEFS_VH
// ---------------------------------------------------------------
// register offsets in the memory-mapped register space
// ---------------------------------------------------------------
`define WSC_OFS_RANGES 16'h0028
`define WSC_OFS_BANK 16'h0029
`define WSC_OFS_MULT 16'h002B
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define WSC_RST_RANGES 16'h7FFF
`define WSC_RST_BANK 16'hF800
`define WSC_RST_MULT 16'h0000
`define WSC_RST_MODE 3'h0
// ---------------------------------------------------------------
// wait_state_ranges field positions
// ---------------------------------------------------------------
`define WSC_XRG_BIT 15
`define WSC_IO_HI 14
`define WSC_IO_LO 12
`define WSC_DHI_HI 11
`define WSC_DHI_LO 9
`define WSC_DLO_HI 8
`define WSC_DLO_LO 6
`define WSC_PHI_HI 5
`define WSC_PHI_LO 3
`define WSC_PLO_HI 2
`define WSC_PLO_LO 0
// ---------------------------------------------------------------
// wait_state_multiplier_control and bank_switch_control fields
// ---------------------------------------------------------------
`define WSC_MULT_BIT 0
`define WSC_BNK_HI 15
`define WSC_BNK_LO 12
`define WSC_TURN_BIT 11
`define WSC_HKEEP_BIT 2
`define WSC_DKEEP_BIT 1
`define WSC_BUSOFF_BIT 0
// writable bits; everything else reads zero
`define WSC_MASK_MULT 16'h0001
`define WSC_MASK_BANK 16'hF807
// ---------------------------------------------------------------
// access spaces and timing counts
// ---------------------------------------------------------------
`define WSC_SP_PROG 2'h0
`define WSC_SP_DATA 2'h1
`define WSC_SP_IO 2'h2
`define WSC_GAP_CYCLES 4'h1
`endif

//--- hdl/wsc_gap_detect.v
// decides whether one idle cycle precedes a new access
module wsc_gap_detect (
   bank_mask,
   turn_en,
   prev_valid,
   prev_space,
   prev_rd,
   prev_addr,
   space,
   rd,
   addr,
   gap
);
`include "wsc_defs.vh"
   input wire [3:0] bank_mask;
   input wire turn_en;
   input wire prev_valid;
   input wire [1:0] prev_space;
   input wire prev_rd;
   input wire [19:0] prev_addr;
   input wire [1:0] space;
   input wire rd;
   input wire [19:0] addr;
   output reg gap;

   reg bank_chg;
   reg mem_prev;
   reg mem_now;

   // ---------------------------------------------------------------
   // bank change, space crossing and read turnaround
   // ---------------------------------------------------------------
   always @* begin
      // masked upper bits; program pages also count as banks
      bank_chg = (|((prev_addr[15:12] ^ addr[15:12]) & bank_mask)) || // RULE12
         ((space == `WSC_SP_PROG) && (prev_addr[19:16] != addr[19:16]));
      mem_prev = (prev_space != `WSC_SP_IO);
      mem_now = (space != `WSC_SP_IO);
      gap = 1'b0;
      if (prev_valid && mem_prev && mem_now) begin
         if ((prev_space == space) && bank_chg) begin
            gap = 1'b1; // RULE10
         end
         if ((prev_space == `WSC_SP_DATA) && (space == `WSC_SP_PROG)) begin
            gap = 1'b1; // RULE11
         end
         if (turn_en && prev_rd && rd && (prev_space != space)) begin
            gap = 1'b1; // RULE13
         end
      end
   end
endmodule // wsc_gap_detect

//--- hdl/wsc_wait_calc.v
// range selection and multiplier for the effective wait count
module wsc_wait_calc (
   ranges,
   mult,
   space,
   addr,
   wait_cnt
);
`include "wsc_defs.vh"
   input wire [15:0] ranges;
   input wire mult;
   input wire [1:0] space;
   input wire [19:0] addr;
   output reg [3:0] wait_cnt;

   reg [2:0] base;

   // ---------------------------------------------------------------
   // pick the base field by space and address, then scale it
   // ---------------------------------------------------------------
   always @* begin
      base = ranges[`WSC_IO_HI:`WSC_IO_LO]; // RULE2
      if (space == `WSC_SP_DATA) begin
         if (addr[15]) begin
            base = ranges[`WSC_DHI_HI:`WSC_DHI_LO]; // RULE3
         end else begin
            base = ranges[`WSC_DLO_HI:`WSC_DLO_LO]; // RULE4
         end
      end else if (space == `WSC_SP_PROG) begin
         if (ranges[`WSC_XRG_BIT]) begin // RULE1
            // upper field ignored, one field covers all pages
            base = ranges[`WSC_PLO_HI:`WSC_PLO_LO]; // RULE6 RULE7
         end else if (addr[15]) begin
            base = ranges[`WSC_PHI_HI:`WSC_PHI_LO]; // RULE5
         end else begin
            base = ranges[`WSC_PLO_HI:`WSC_PLO_LO]; // RULE7
         end
      end
      // doubling keeps the maximum at fourteen
      wait_cnt = mult ? {base, 1'b0} : {1'b0, base}; // RULE8 RULE21
   end
endmodule // wsc_wait_calc

//--- tb/test_wsc_bus_ctrl.sv
// self-checking bench for the external bus timing block
`include "wsc_defs.vh"
module test_wsc_bus_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_b = 1'b0, mmr_wr = 1'b0, mmr_rd = 1'b0, acc_req = 1'b0, acc_rd = 1'b0, mode_wr = 1'b0;
   logic [15:0] mmr_addr = 16'h0000, mmr_wdata = 16'h0000;
   logic [1:0] acc_space = 2'h0;
   logic [19:0] acc_addr = 20'h0_0000, pa = 20'h0_0000;
   logic [2:0] mode_wdata = 3'h0;
   logic [3:0] stall = 4'h0;
   wire [15:0] mmr_rdata_q;
   wire acc_busy_q, acc_done_q, ext_ready, ext_strobe_b_q, ext_bus_off_q, hkeep, dkeep, clk_off, rom, boot, ovl;
   logic [15:0] rng = `WSC_RST_RANGES, bnk = `WSC_RST_BANK, acc_q[$], rd_q[$];
   logic mul = 1'b0, pv = 1'b0, prd = 1'b0, rseen = 1'b0;
   logic [1:0] ps = 2'h0;
   int mismatches = 0, total_checks = 0, bcnt = 0;
   always #5 clk = ~clk;
   wsc_bus_ctrl u_dut (.clk(clk), .rst_b(rst_b), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr), .mmr_rd(mmr_rd),
      .mmr_wdata(mmr_wdata), .mmr_rdata_q(mmr_rdata_q), .acc_req(acc_req), .acc_space(acc_space), .acc_rd(acc_rd),
      .acc_addr(acc_addr), .acc_busy_q(acc_busy_q), .acc_done_q(acc_done_q), .ext_ready(ext_ready), .ext_addr_q(),
      .ext_strobe_b_q(ext_strobe_b_q), .ext_rw_q(), .ext_prog_sel_b_q(), .ext_data_sel_b_q(), .ext_io_sel_b_q(),
      .ext_bus_off_q(ext_bus_off_q), .host_bus_keeper_enable_q(hkeep), .data_bus_keeper_enable_q(dkeep),
      .wait_clk_off_q(clk_off), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .data_rom_enable_q(rom),
      .boot_mode_select_q(boot), .ram_overlay_bit_q(ovl));
   wsc_ext_mem u_mem (.clk(clk), .rst_b(rst_b), .ext_strobe_b_q(ext_strobe_b_q), .stall(stall), .ext_ready(ext_ready));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      if (a == `WSC_OFS_RANGES) rng = d;
      if (a == `WSC_OFS_BANK) bnk = d & `WSC_MASK_BANK;
      if (a == `WSC_OFS_MULT) mul = d[0];
      mmr_addr = a;
      mmr_wdata = d;
      mmr_wr = 1'b1;
      cyc(1);
      mmr_wr = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] exp);
      rd_q.push_back(exp);
      mmr_addr = a;
      mmr_rd = 1'b1;
      cyc(1);
      mmr_rd = 1'b0;
      cyc(1);
   endtask
   // expected waits: base of the matching range, doubled by the multiplier
   function automatic int wexp(input logic [1:0] sp, input logic [19:0] a);
      logic [2:0] b;
      if (sp == `WSC_SP_IO) b = rng[14:12];
      else if (sp == `WSC_SP_DATA) b = a[15] ? rng[11:9] : rng[8:6];
      else b = (!rng[15] && a[15]) ? rng[5:3] : rng[2:0];
      return mul ? 2 * b : b;
   endfunction
   // expected idle cycle from the previous access
   function automatic int gexp(input logic [1:0] sp, input logic r, input logic [19:0] a);
      if (!pv || sp == `WSC_SP_IO || ps == `WSC_SP_IO) return 0;
      if (sp == ps) return (((a[15:12] ^ pa[15:12]) & bnk[15:12]) != 4'h0) || (sp == `WSC_SP_PROG && a[19:16] != pa[19:16]);
      if (ps == `WSC_SP_DATA) return 1;
      return bnk[11] && r && prd;
   endfunction
   task automatic acc(input logic [1:0] sp, input logic r, input logic [19:0] a0);
      int w, i;
      logic [19:0] a;
      a = (sp == `WSC_SP_PROG) ? a0 : {4'h0, a0[15:0]};
      w = wexp(sp, a);
      acc_q.push_back(16'(1 + w + gexp(sp, r, a) + ((stall > w) ? stall - w : 0)));
      {pv, ps, prd, pa} = {1'b1, sp, r, a};
      {acc_space, acc_rd, acc_addr, acc_req} = {sp, r, a, 1'b1};
      i = 0;
      while (acc_busy_q !== 1'b1 && i < 4) begin
         cyc(1);
         i++;
      end
      acc_req = 1'b0;
   endtask
   task automatic wdone();
      int i;
      i = 0;
      while (acc_done_q !== 1'b1 && i < 40) begin
         cyc(1);
         i++;
      end
   endtask
   // results: busy length per access, read data one cycle after each read
   always @(posedge clk) begin
      if (!rst_b) bcnt = 0;
      if (acc_busy_q === 1'b1) bcnt++;
      if (acc_done_q === 1'b1) begin
         chk(16'(bcnt), acc_q.size() > 0 ? acc_q.pop_front() : 16'hFFFF, "busy cycles");
         bcnt = 0;
      end
      if (rseen) chk(mmr_rdata_q, rd_q.size() > 0 ? rd_q.pop_front() : 16'hFFFF, "read data");
      rseen = mmr_rd;
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0 && acc_q.size() == 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      void'($urandom(32'ha6a00e9f));
      cyc(8);
      rst_b = 1'b1;
      acc(`WSC_SP_PROG, 1'b1, 20'h3_8000);
      wdone();
      acc(`WSC_SP_DATA, 1'b1, 20'h0_1000);
      wdone();
      rd(`WSC_OFS_RANGES, `WSC_RST_RANGES);
      rd(`WSC_OFS_BANK, `WSC_RST_BANK);
      wr(`WSC_OFS_MULT, 16'hFFFF);
      wr(`WSC_OFS_BANK, 16'hFFFE);
      wr(16'h002A, 16'hFFFF);
      rd(`WSC_OFS_MULT, 16'h0001);
      rd(`WSC_OFS_BANK, 16'hF806);
      rd(16'h002A, 16'h0000);
      $display("test registers done");
      // random ranges, bank sizes and access streams
      for (int k = 0; k < 6; k++) begin
         wr(`WSC_OFS_RANGES, 16'($urandom));
         wr(`WSC_OFS_BANK, {4'hF << ($urandom % 5), 11'($urandom) & 11'h407, 1'b0});
         wr(`WSC_OFS_MULT, 16'($urandom));
         rd(`WSC_OFS_RANGES, rng);
         chk({13'h0000, hkeep, dkeep, clk_off}, {13'h0000, bnk[2:1], rng[14:0] == 15'h0000}, "levels");
         for (int j = 0; j < 6; j++) begin
            acc(2'($urandom % 3), 1'($urandom), j[0] ? pa ^ 20'h0_4400 : 20'($urandom));
            wdone();
         end
      end
      $display("test random accesses done");
      wr(`WSC_OFS_RANGES, 16'h0000);
      chk(16'(clk_off), 16'h0001, "clock gate");
      acc(`WSC_SP_IO, 1'b1, 20'h0_0000);
      wdone();
      stall = 4'h3;
      acc(`WSC_SP_DATA, 1'b0, 20'h0_0010);
      wdone();
      stall = 4'h0;
      wr(`WSC_OFS_RANGES, 16'h7FFF);
      wr(`WSC_OFS_MULT, 16'h0001);
      acc(`WSC_SP_IO, 1'b0, 20'h0_FFFF);
      wr(`WSC_OFS_BANK, bnk | 16'h0001);
      wdone();
      cyc(2);
      {mode_wdata, mode_wr, acc_req} = {3'h7, 1'b1, 1'b1};
      cyc(1);
      mode_wr = 1'b0;
      cyc(3);
      chk({11'h000, ext_bus_off_q, acc_busy_q, rom, boot, ovl}, 16'h0010, "locked");
      acc_req = 1'b0;
      wr(`WSC_OFS_BANK, bnk & 16'hFFFE);
      {mode_wdata, mode_wr} = {3'h5, 1'b1};
      cyc(1);
      mode_wr = 1'b0;
      cyc(1);
      chk({12'h000, ext_bus_off_q, rom, boot, ovl}, 16'h0005, "unlocked");
      $display("test ready and bus off done");
      rst_b = 1'b0;
      cyc(2);
      rst_b = 1'b1;
      {rng, bnk, mul, pv} = {`WSC_RST_RANGES, `WSC_RST_BANK, 1'b0, 1'b0};
      rd(`WSC_OFS_BANK, `WSC_RST_BANK);
      acc(`WSC_SP_PROG, 1'b1, 20'h0_0100);
      wdone();
      cyc(2);
      $display("test second reset done");
      complete_run();
   end
endmodule // test_wsc_bus_ctrl
bind wsc_bus_ctrl wsc_bus_ctrl_asserts u_chk (.clk(clk), .rst_b(rst_b), .mmr_addr(mmr_addr), .mmr_wr(mmr_wr),
   .mmr_rd(mmr_rd), .mmr_wdata(mmr_wdata), .mmr_rdata_q(mmr_rdata_q), .acc_busy_q(acc_busy_q), .ext_ready(ext_ready),
   .ext_addr_q(ext_addr_q), .ext_strobe_b_q(ext_strobe_b_q), .ext_bus_off_q(ext_bus_off_q),
   .host_bus_keeper_enable_q(host_bus_keeper_enable_q), .data_bus_keeper_enable_q(data_bus_keeper_enable_q),
   .wait_clk_off_q(wait_clk_off_q), .mode_wr(mode_wr), .mode_wdata(mode_wdata), .data_rom_enable_q(data_rom_enable_q),
   .boot_mode_select_q(boot_mode_select_q), .ram_overlay_bit_q(ram_overlay_bit_q));

//--- tb/wsc_bus_ctrl_asserts.sv
// port-level assertions for the external bus timing block
`include "wsc_defs.vh"
module wsc_bus_ctrl_asserts (
   input wire clk,
   input wire rst_b,
   input wire [15:0] mmr_addr,
   input wire mmr_wr,
   input wire mmr_rd,
   input wire [15:0] mmr_wdata,
   input wire [15:0] mmr_rdata_q,
   input wire acc_busy_q,
   input wire ext_ready,
   input wire [19:0] ext_addr_q,
   input wire ext_strobe_b_q,
   input wire ext_bus_off_q,
   input wire host_bus_keeper_enable_q,
   input wire data_bus_keeper_enable_q,
   input wire wait_clk_off_q,
   input wire mode_wr,
   input wire [2:0] mode_wdata,
   input wire data_rom_enable_q,
   input wire boot_mode_select_q,
   input wire ram_overlay_bit_q
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_q;
   logic stall_q, cfg_q, off_q;
   logic [1:0] keep_q;
   wire [2:0] mode_now = {data_rom_enable_q, boot_mode_select_q, ram_overlay_bit_q};
   // strobe length; a ready stall makes the length open-ended, so it is flagged
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 5'h00;
         stall_q <= 1'b0;
      end else if (ext_strobe_b_q) begin
         cnt_q <= 5'h00;
         stall_q <= 1'b0;
      end else begin
         cnt_q <= cnt_q + 5'h01;
         stall_q <= stall_q | !ext_ready;
      end
   end
   // shadow of settings seen on the register bus
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q <= 1'b0;
         off_q <= 1'b0;
         keep_q <= 2'h0;
      end else if (mmr_wr) begin
         if (mmr_addr == `WSC_OFS_RANGES || mmr_addr == `WSC_OFS_MULT) cfg_q <= 1'b1;
         if (mmr_addr == `WSC_OFS_BANK) begin
            off_q <= mmr_wdata[0];
            keep_q <= mmr_wdata[2:1];
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_reset_waits: assert property ($rose(ext_strobe_b_q) && !cfg_q && !stall_q |-> cnt_q == 5'h08)
      else $error("strobe length not seven waits");
   a_strobe_max: assert property ($rose(ext_strobe_b_q) && !stall_q |-> cnt_q <= 5'h0F)
      else $error("strobe longer than fourteen waits");
   a_gate_zero: assert property ($rose(ext_strobe_b_q) && wait_clk_off_q && !stall_q |-> cnt_q == 5'h01)
      else $error("waits inserted with gated generator");
   a_off_idle: assert property (ext_bus_off_q |-> !acc_busy_q && ext_strobe_b_q && ext_addr_q == 20'h0_0000)
      else $error("bus active while off");
   a_off_after: assert property ($rose(ext_bus_off_q) |-> off_q && $past(ext_ready))
      else $error("bus off during a cycle");
   a_mode_lock: assert property (off_q && mode_wr |=> $stable(mode_now))
      else $error("mode bits changed while off");
   a_mode_write: assert property (!off_q && mode_wr |=> mode_now == $past(mode_wdata))
      else $error("mode bits not written");
   a_host_keep: assert property (host_bus_keeper_enable_q == $past(keep_q[1]))
      else $error("host keeper enable wrong");
   a_data_keep: assert property (data_bus_keeper_enable_q == $past(keep_q[0]))
      else $error("data keeper enable wrong");
   a_resv_read: assert property ($past(mmr_rd) && $past(mmr_addr) == `WSC_OFS_MULT |-> mmr_rdata_q[15:1] == 15'h0000)
      else $error("reserved bits not zero");
   c_off: cover property ($rose(ext_bus_off_q));
   c_stall: cover property (!ext_strobe_b_q && !ext_ready);
   c_lock: cover property (off_q && mode_wr);
endmodule // wsc_bus_ctrl_asserts

//--- tb/wsc_ext_mem.sv
// external memory model answering on the hardware ready line
module wsc_ext_mem (
   input wire clk,
   input wire rst_b,
   input wire ext_strobe_b_q,
   input wire [3:0] stall,
   output wire ext_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] left_q;
   // slow part: not ready for the first stall strobe cycles of each access
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) left_q <= 4'h0;
      else if (ext_strobe_b_q) left_q <= stall;
      else if (left_q != 4'h0) left_q <= left_q - 4'h1;
   end
   assign ext_ready = !(!ext_strobe_b_q && left_q != 4'h0);
endmodule // wsc_ext_mem
